/* File: rtl/gtc_timer.v */
// Gated sixteen bit timer/counter with prescaler, wide access buffer and Avalon-MM slave.
//
// Operation
// - Sixteen bit counter, byte writes update live count.
// - Off unless on; gate used when gate_enable.
// - Five bit field selects the clock source.
// - Instruction clock counts one, system clock four.
// - Counter mode needs falling edge before first increment.
// - External source counts rising edges, sync or not.
// - Prescaler divides by 1,2,4,8, hidden from software.
// - Low byte write clears prescaler; wide high not.
// - Bypass counts unsynchronised (the pin is still registered twice here), overflow can wake processor.
// - Mode switch may lose or gain one (no slip here, as both paths share the same registers).
// - Byte reads stay valid with asynchronous clock.
// - Wide mode high byte goes through buffer.
// - Low byte read snapshots high into buffer.
// - Wide write loads buffer and low together.
// - Without wide mode bytes read independently.
// - Gate mode counts only while gate active.
// - Gate active when gate equals polarity.
// - Any wrap past all ones sets overflow flag, e.g. FFFC to 0000 with step four.
`timescale 1ns/1ps
`include "gtc_timer_regs.vh"

module gtc_timer (
  // Clock, enable and reset
  input  wire                   core_clk,
  input  wire                   clkEn,
  input  wire                   rst_n,
  // Avalon-MM slave
  input  wire [`GTC_ADDR_W-1:0] avsAddress,
  input  wire                   avsRead,
  input  wire                   avsWrite,
  input  wire [7:0]             avsWriteData,
  output reg  [7:0]             avsReadData,
  output reg                    avsWaitRequest,
  // Pins
  input  wire                   external_clock_pin,
  input  wire                   gate_signal,
  // Events
  output reg                    overflowIrq,
  output reg                    wakeRequest
);

  // Software registers and internal state.
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  gate_reg;
  reg  [4:0]  clkSel_reg;
  reg  [15:0] count_reg;
  reg  [15:0] count_next;
  reg  [7:0]  highBuf_reg;
  reg  [2:0]  prescale_reg;
  reg  [2:0]  prescale_next;
  reg  [1:0]  instrDiv_reg;
  reg         overflow_reg;
  reg         armed_reg;
  reg         armed_next;
  reg         accessDone_reg;
  // Synchronisers.
  reg         extMeta_reg;
  reg         extSync_reg;
  reg         extPrev_reg;
  reg         gateMeta_reg;
  reg         gateSync_reg;
  reg         onPrev_reg;

  wire       counterOn    = ctrl_reg[`GTC_CTRL_ON];
  wire       wideMode     = ctrl_reg[`GTC_CTRL_WIDE];
  wire       bypassSync   = ctrl_reg[`GTC_CTRL_BYPASS];
  wire [1:0] prescaleSel  = ctrl_reg[`GTC_CTRL_PS_HI:`GTC_CTRL_PS_LO];
  wire       gateEnable   = gate_reg[`GTC_GATE_EN];
  wire       gatePolarity = gate_reg[`GTC_GATE_POL];

  wire busReq    = (avsRead | avsWrite) & avsWaitRequest;
  wire wrLow     = busReq & avsWrite & (avsAddress == `GTC_OFF_LOW);
  wire wrHigh    = busReq & avsWrite & (avsAddress == `GTC_OFF_HIGH);
  wire rdLow     = busReq & avsRead & (avsAddress == `GTC_OFF_LOW);

  // Prescale terminal count: true when the divided tick has arrived.
  function prescaleDone;
    input [2:0] cnt;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    prescaleDone = 1'b1;
        2'h1:    prescaleDone = (cnt[0] == 1'b1);
        2'h2:    prescaleDone = (cnt[1:0] == 2'h3);
        default: prescaleDone = (cnt == 3'h7);
      endcase
    end
  endfunction

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extMeta_reg  <= 1'b0;
      extSync_reg  <= 1'b0;
      gateMeta_reg <= 1'b0;
      gateSync_reg <= 1'b0;
    end else if (clkEn) begin
      extMeta_reg  <= external_clock_pin;
      extSync_reg  <= extMeta_reg;
      gateMeta_reg <= gate_signal;
      gateSync_reg <= gateMeta_reg;
    end
  end

  // The bypass path has no separate clock domain here, so the pin is still
  // registered twice; both paths share the same edge register.
  // mode switch slip
  // With no extra stage in either path, a mode change causes no one-count slip here.
  wire extLevel = extSync_reg;
  wire extRise  = extLevel & ~extPrev_reg;
  wire extFall  = ~extLevel & extPrev_reg;
  wire gateActive = (gateSync_reg == gatePolarity);
  wire countEnable = counterOn & (~gateEnable | gateActive);

  reg        srcTick;
  reg [15:0] step;
  always @* begin
    srcTick = 1'b0;
    step    = 16'h0001;
    case (clkSel_reg)
      `GTC_CS_INSTR: srcTick = (instrDiv_reg == `GTC_INSTR_DIV);
      `GTC_CS_SYSCLK: begin
        srcTick = (instrDiv_reg == `GTC_INSTR_DIV);
        step    = `GTC_FULL_STEP;
      end
      `GTC_CS_EXT: srcTick = extRise & armed_reg;
      default: srcTick = 1'b0;
    endcase
  end

  wire tick = srcTick & countEnable;

  always @* begin
    prescale_next = prescale_reg;
    count_next    = count_reg;
    armed_next    = armed_reg;
    if (extFall) begin
      armed_next = 1'b1;
    end
    if (!counterOn || (counterOn && !onPrev_reg && extLevel)) begin
      armed_next = 1'b0;
    end
    if (tick) begin
      if (prescaleDone(prescale_reg, prescaleSel)) begin
        prescale_next = 3'h0;
        count_next    = count_reg + step;
      end else begin
        prescale_next = prescale_reg + 3'h1;
      end
    end
    if (wrLow) begin
      prescale_next = 3'h0;
      armed_next    = 1'b0;
      if (wideMode) begin
        count_next = {highBuf_reg, avsWriteData};
      end else begin
        count_next = {count_reg[15:8], avsWriteData};
      end
    end else if (wrHigh && !wideMode) begin
      prescale_next = 3'h0;
      armed_next    = 1'b0;
      count_next    = {avsWriteData, count_reg[7:0]};
    end
  end

  wire rollover = tick & prescaleDone(prescale_reg, prescaleSel) & ~wrLow
                  & ~(wrHigh & ~wideMode) & (count_next < count_reg);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg    <= `GTC_COUNT_RESET;
      prescale_reg <= 3'h0;
      instrDiv_reg <= 2'h0;
      armed_reg    <= 1'b0;
      extPrev_reg  <= 1'b0;
      onPrev_reg   <= 1'b0;
    end else if (clkEn) begin
      count_reg    <= count_next;
      prescale_reg <= prescale_next;
      instrDiv_reg <= instrDiv_reg + 2'h1;
      armed_reg    <= armed_next;
      extPrev_reg  <= extLevel;
      onPrev_reg   <= counterOn;
    end
  end

  // Bus slave: one wait cycle, then the access completes.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avsWaitRequest <= 1'b1;
      accessDone_reg <= 1'b0;
      avsReadData    <= 8'h00;
      ctrl_reg       <= `GTC_CTRL_RESET;
      gate_reg       <= `GTC_GATE_RESET;
      clkSel_reg     <= `GTC_CLKSEL_RESET;
      highBuf_reg    <= 8'h00;
      overflow_reg   <= 1'b0;
      overflowIrq    <= 1'b0;
      wakeRequest    <= 1'b0;
    end else if (clkEn) begin
      avsWaitRequest <= ~busReq;
      if (busReq && avsWrite) begin
        case (avsAddress)
          `GTC_OFF_CTRL:   ctrl_reg   <= avsWriteData;
          `GTC_OFF_GATE:   gate_reg   <= {avsWriteData[7:6], 6'h00};
          `GTC_OFF_CLKSEL: clkSel_reg <= avsWriteData[4:0];
          `GTC_OFF_HIGH:   if (wideMode) highBuf_reg <= avsWriteData;
          default: ;
        endcase
      end
      if (rdLow && wideMode) begin
        highBuf_reg <= count_reg[15:8];
      end
      if (busReq && avsRead) begin
        case (avsAddress)
          `GTC_OFF_LOW:    avsReadData <= count_reg[7:0];
          `GTC_OFF_HIGH:   avsReadData <= wideMode ? highBuf_reg : count_reg[15:8];
          `GTC_OFF_CTRL:   avsReadData <= ctrl_reg;
          `GTC_OFF_GATE:   avsReadData <= gate_reg;
          `GTC_OFF_CLKSEL: avsReadData <= {3'h0, clkSel_reg};
          `GTC_OFF_STATUS: avsReadData <= {7'h00, overflow_reg};
          default:         avsReadData <= 8'h00;
        endcase
      end
      if (rollover) begin
        overflow_reg <= 1'b1;
      end else if (busReq && avsWrite && avsAddress == `GTC_OFF_STATUS
                   && avsWriteData[`GTC_STAT_OVF]) begin
        overflow_reg <= 1'b0;
      end
      // The output follows the flag's next value, so a clear drops it at once.
      overflowIrq <= rollover | (overflow_reg & ~(busReq && avsWrite
                     && avsAddress == `GTC_OFF_STATUS && avsWriteData[`GTC_STAT_OVF]));
      wakeRequest <= rollover & bypassSync & (clkSel_reg == `GTC_CS_EXT);
    end
  end

endmodule

/* File: rtl/gtc_timer_regs.vh */
// Register offsets, field positions, reset values and clock source codes of the gated timer.
`ifndef GTC_TIMER_REGS_VH
`define GTC_TIMER_REGS_VH

`define GTC_ADDR_W            4
`define GTC_OFF_LOW           4'h0
`define GTC_OFF_HIGH          4'h1
`define GTC_OFF_CTRL          4'h2
`define GTC_OFF_GATE          4'h3
`define GTC_OFF_CLKSEL        4'h4
`define GTC_OFF_STATUS        4'h5

`define GTC_CTRL_ON           0
`define GTC_CTRL_WIDE         1
`define GTC_CTRL_BYPASS       2
`define GTC_CTRL_PS_LO        4
`define GTC_CTRL_PS_HI        5
`define GTC_GATE_EN           7
`define GTC_GATE_POL          6
`define GTC_STAT_OVF          0

`define GTC_CTRL_RESET        8'h00
`define GTC_GATE_RESET        8'h00
`define GTC_CLKSEL_RESET      5'h00
`define GTC_COUNT_RESET       16'h0000
`define GTC_COUNT_ALLONES     16'hFFFF

`define GTC_CS_INSTR          5'h01
`define GTC_CS_SYSCLK         5'h02
`define GTC_CS_EXT            5'h00

`define GTC_INSTR_DIV         2'h3
`define GTC_FULL_STEP         16'h0004

`endif

/* File: tb/gtc_pin_model.sv */
// Model of the external clock pin and gate source.
`timescale 1ns/1ps
module gtc_pin_model (
  // Clock and reset
  input  wire core_clk,
  input  wire rst_n,
  // Bench control
  input  wire run,
  input  wire gateLvl,
  // Pins
  output reg  extClk,
  output wire gateOut
);
  reg [1:0] divReg;
  // rising edge source
  // The pin rests low between bursts, so a burst always starts with a rise.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divReg <= 2'h0;
      extClk <= 1'b0;
    end else begin
      divReg <= divReg + 2'h1;
      if (!run)
        extClk <= 1'b0;
      else if (divReg == 2'h3)
        extClk <= ~extClk;
    end
  end
  assign gateOut = gateLvl;
endmodule

/* File: tb/gtc_timer_chk_sva.sv */
// Concurrent checks on the bus and event ports of the timer.
`timescale 1ns/1ps
module gtc_timer_chk (
  // Clock and reset
  input wire       core_clk,
  input wire       clkEn,
  input wire       rst_n,
  // Bus and events
  input wire [3:0] avsAddress,
  input wire       avsRead,
  input wire       avsWrite,
  input wire [7:0] avsWriteData,
  input wire [7:0] avsReadData,
  input wire       avsWaitRequest,
  input wire       overflowIrq,
  input wire       wakeRequest
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence takeRd;
    avsRead && avsWaitRequest && clkEn;
  endsequence
  sequence clrSt;
    avsWrite && avsWaitRequest && clkEn && avsAddress == 4'h5 && avsWriteData[0];
  endsequence
  resp_one_a: assert property ((avsRead || avsWrite) && avsWaitRequest && clkEn
    |=> !avsWaitRequest) else $error("request not answered after one cycle");
  wait_back_a: assert property (!avsWaitRequest && clkEn |=> avsWaitRequest)
    else $error("waitrequest low for more than one cycle");
  idle_hold_a: assert property (avsWaitRequest && !avsRead && !avsWrite
    |=> avsWaitRequest) else $error("answer without request");
  unmapped_zero_a: assert property (takeRd ##0 avsAddress > 4'h5
    |=> avsReadData == 8'h00) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(avsRead && avsWaitRequest && clkEn)
    |=> $stable(avsReadData)) else $error("read data changed without read");
  irq_sticky_a: assert property (overflowIrq and not clrSt |=> overflowIrq)
    else $error("overflow flag dropped without clear");
  wake_pulse_a: assert property (wakeRequest |=> !wakeRequest)
    else $error("wake request longer than one cycle");
  wake_flag_a: assert property (wakeRequest |-> ##[0:1] overflowIrq)
    else $error("wake without overflow flag");
endmodule

bind gtc_timer gtc_timer_chk chk (.core_clk(core_clk), .clkEn(clkEn), .rst_n(rst_n),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsWriteData(avsWriteData), .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest), .overflowIrq(overflowIrq), .wakeRequest(wakeRequest));

/* File: tb/tb.sv */
// Self-checking bench for the gated timer.
`timescale 1ns/1ps
module tb;
  reg         core_clk = 1'b0;
  reg         rst_n    = 1'b0;
  reg  [3:0]  addr     = 4'h0;
  reg         rd       = 1'b0;
  reg         wr       = 1'b0;
  reg  [7:0]  wd       = 8'h00;
  reg         run      = 1'b0;
  reg         gLvl     = 1'b0;
  reg         en       = 1'b1;
  wire [7:0]  rdata;
  wire        waitReq, irq, wake, extPin, gSig;
  integer     errors   = 0;
  integer     n_checks = 0;
  integer     wakes    = 0;
  integer     i, w0;
  reg  [15:0] cnt;
  reg  [7:0]  q;
  gtc_timer dut (.core_clk(core_clk), .clkEn(en), .rst_n(rst_n), .avsAddress(addr),
    .avsRead(rd), .avsWrite(wr), .avsWriteData(wd), .avsReadData(rdata),
    .avsWaitRequest(waitReq), .external_clock_pin(extPin), .gate_signal(gSig),
    .overflowIrq(irq), .wakeRequest(wake));
  gtc_pin_model pins (.core_clk(core_clk), .rst_n(rst_n), .run(run), .gateLvl(gLvl),
    .extClk(extPin), .gateOut(gSig));
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (wake === 1'b1) wakes <= wakes + 1;
  task results;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] lo, input [15:0] hi);
    begin
      n_checks = n_checks + 1;
      if (^g === 1'bx || g < lo || g > hi) begin
        errors = errors + 1;
        $display("unexpected t=%0t got %h exp %h..%h", $time, g, lo, hi);
      end
    end
  endtask
  // Holds the request until waitrequest is sampled low, then releases it.
  task bus(input w, input [3:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge core_clk);
      while (waitReq !== 1'b0) @(posedge core_clk);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask
  task rc;
    begin
      bus(0, 4'h0, 8'h00);
      cnt[7:0] = q;
      bus(0, 4'h1, 8'h00);
      cnt[15:8] = q;
    end
  endtask
  task run_n(input [7:0] c, input [4:0] cs, input integer n);
    begin
      bus(1, 4'h4, {3'h0, cs});
      bus(1, 4'h1, 8'h00);
      bus(1, 4'h0, 8'h00);
      bus(1, 4'h2, c);
      repeat (n) @(posedge core_clk);
      bus(1, 4'h2, 8'h00);
      rc;
    end
  endtask
  task t_clk;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        run_n({2'h0, i[1:0], 4'h1}, 5'h01, 64);
        chk(cnt, (16 >> i) - 1, (18 >> i) + 1);
      end
      run_n(8'h01, 5'h02, 64);
      chk(cnt, 60, 72);
      run_n(8'h01, 5'h1F, 64);
      chk(cnt, 0, 0);
      run_n(8'h00, 5'h01, 64);
      chk(cnt, 0, 0);
      $display("clock test done");
    end
  endtask
  task t_gate;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        gLvl <= i[0];
        bus(1, 4'h3, {1'b1, i[1], 6'h00});
        run_n(8'h01, 5'h01, 64);
        if (i[1] == i[0]) chk(cnt, 15, 19);
        else chk(cnt, 0, 0);
      end
      bus(1, 4'h3, 8'h00);
      $display("gate test done");
    end
  endtask
  task t_wide;
    begin
      bus(0, 4'hF, 8'h00);
      chk(q, 0, 0);
      bus(1, 4'h2, 8'h02);
      bus(1, 4'h1, 8'h12);
      bus(0, 4'h0, 8'h00);
      bus(0, 4'h1, 8'h00);
      chk(q, 0, 0);
      bus(1, 4'h1, 8'h12);
      bus(1, 4'h0, 8'h34);
      bus(0, 4'h0, 8'h00);
      bus(0, 4'h1, 8'h00);
      chk(q, 8'h12, 8'h12);
      bus(1, 4'h2, 8'h00);
      rc;
      chk(cnt, 16'h1234, 16'h1234);
      $display("wide test done");
    end
  endtask
  // A low clock enable must freeze the count, so only the enabled span counts.
  task t_freeze;
    begin
      bus(1, 4'h4, 8'h01);
      bus(1, 4'h1, 8'h00);
      bus(1, 4'h0, 8'h00);
      bus(1, 4'h2, 8'h01);
      en <= 1'b0;
      repeat (64) @(posedge core_clk);
      en <= 1'b1;
      repeat (64) @(posedge core_clk);
      bus(1, 4'h2, 8'h00);
      rc;
      chk(cnt, 15, 19);
      $display("freeze test done");
    end
  endtask
  // stop before write
  // The counter is stopped before each count write.
  task t_ext(input byp);
    begin
      w0 = wakes;
      bus(1, 4'h5, 8'h01);
      bus(1, 4'h4, 8'h00);
      bus(1, 4'h1, 8'hFF);
      bus(1, 4'h0, 8'hFE);
      bus(1, 4'h2, {5'h00, byp, 2'h1});
      run <= 1'b1;
      repeat (32) @(posedge core_clk);
      run <= 1'b0;
      repeat (8) @(posedge core_clk);
      bus(1, 4'h2, 8'h00);
      rc;
      chk(cnt, 16'h0001, 16'h0001);
      chk(irq, 1, 1);
      chk(16'(wakes - w0), byp, byp);
      bus(1, 4'h5, 8'h01);
      bus(0, 4'h5, 8'h00);
      chk(q, 0, 0);
      $display("external test done");
    end
  endtask
  initial begin
    #(25 * 20000);
    errors = errors + 1;
    results;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(0, 4'h2, 8'h00);
    chk(q, 0, 0);
    t_clk;
    t_gate;
    t_wide;
    t_freeze;
    t_ext(1'b0);
    t_ext(1'b1);
    results;
  end
endmodule
